/* File: hw/sopc_pin_filter.sv */
/*
 Open-drain pin readback filter: reports a mismatch between driven-low
 and read-back-high only once it has stood for the filter count.
 Assumes the read-back level is synchronous to clock.
*/
`timescale 1ns/1ns
module sopc_pin_filter #(
	parameter int COUNT = 400
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic drivenLow,
	input wire logic pinIn,
	output logic shorted
);
	localparam int CW = $clog2(COUNT + 1);
	logic [CW-1:0] count;
	wire mismatch = drivenLow & pinIn;
	wire done = (count == CW'(COUNT));

	always_ff @(posedge clock) begin
		if (!rst_n || !mismatch) begin
			count <= '0;
		end else if (!done) begin
			count <= count + CW'(1);
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			shorted <= 1'b0;
		end else begin
			shorted <= done;
		end
	end
endmodule // sopc_pin_filter

/* File: hw/sopc_safety_outputs.sv */
/*
 Safety output pin control: power-good, reset and safe-state
 open-drain outputs with priority, reset pulse timing, long stuck-low
 timeout, short-to-high detection and safe-state release gating.
 Assumes monitors, watchdog, error counter and self-tests live outside
 and present synchronous levels and one-cycle pulses.
*/
// Functional notes
// RULE1 - power good low forces reset and safe low
// RULE2 - reset low forces safe-state low
// RULE3 - safe-state alone never forces the others
// RULE4 - reset released after power good and selftest
// RULE5 - power good low on assigned rail faults
// RULE6 - rails for power good chosen by OTP
// RULE7 - standby and power-down drive all outputs low
// RULE8 - logic failure leaves all outputs asserted; the code drives power good, reset and safe-state all low
// RULE9 - init config picks reset faults, reset forces safe
// RULE10 - init config picks safe-state faults
// RULE11 - reset low past eight seconds enters deep failsafe
// RULE12 - reset pulse long or short per select
// RULE13 - reset released about 8 ms after power-up
// RULE14 - pin high while driven low is filtered short
// RULE15 - safe release needs all selftests passed
// RULE16 - safe release needs error counter zero
// RULE17 - release key is inverted reversed seed bits
// RULE18 - intermediate count forces safe or reset pulse
// RULE19 - failed selftest holds safe-state forever
// RULE20 - pin readback only after feedback filter
// RULE21 - wrong key leaves outputs unchanged
`timescale 1ns/1ns
module sopc_safety_outputs #(
	parameter int T8S_COUNT = sopc_pkg::T8S_CYC,
	parameter int TLG_COUNT = sopc_pkg::TLG_CYC,
	parameter int TST_COUNT = sopc_pkg::TST_CYC,
	parameter int TREL_COUNT = sopc_pkg::TREL_CYC,
	parameter int TSC_COUNT = sopc_pkg::TSC_CYC,
	parameter int ECW = 4
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic lowPowerMode,
	input wire logic logicFail,
	input wire logic [sopc_pkg::NRAIL-1:0] railUnder,
	input wire logic [sopc_pkg::NRAIL-1:0] railOver,
	input wire logic [sopc_pkg::NRAIL-1:0] otpRailSel,
	input wire logic [3:0] faultEvent,
	input wire logic [3:0] cfgResetImpact,
	input wire logic [3:0] cfgSafeImpact,
	input wire logic initPhase,
	input wire logic reset_pulse_length_sel,
	input wire logic resetPulseReq,
	input wire logic safeReq,
	input wire logic [ECW-1:0] errCount,
	input wire logic errIntermediate,
	input wire logic [1:0] errImpact,
	input wire logic selftestFirstDone,
	input wire logic logic_selftest,
	input wire logic analog_selftest_first,
	input wire logic analog_selftest_second,
	input wire logic [sopc_pkg::KEY_W-1:0] watchdog_seed_value,
	input wire logic keyWrite,
	input wire logic [sopc_pkg::KEY_W-1:0] safe_output_release_key,
	input wire logic powerGoodIn,
	input wire logic resetIn,
	input wire logic safeIn,
	output logic powerGoodOe,
	output logic resetOe,
	output logic safeOe,
	output logic power_good_out,
	output logic reset_out_n,
	output logic safe_state_out_n,
	output logic resetShortHigh,
	output logic safeShortHigh,
	output logic deep_failsafe_mode,
	output logic keyMismatch
);
	localparam int TW = $clog2(T8S_COUNT + 1);
	localparam int PW = $clog2(TLG_COUNT + TREL_COUNT + 1);
	localparam int FBW = $clog2(sopc_pkg::TFB_CYC + 1);

	sopc_pkg::sopc_state_t state, next_state;
	logic [PW-1:0] pulseCnt;
	logic [TW-1:0] lowCnt;
	logic [FBW-1:0] fbCnt;
	logic safeLatched;
	logic bistLock;
	logic prevInter;

	// which outputs are driven low, deciding in order of priority
	wire railFault = |((railUnder | railOver) & otpRailSel); // [RULE5] [RULE6]
	wire forceAll = lowPowerMode | logicFail; // [RULE7] [RULE8]
	wire pgLow = railFault | forceAll;
	wire resetFault = |(faultEvent & cfgResetImpact); // [RULE9]
	wire safeFault = |(faultEvent & cfgSafeImpact); // [RULE10]
	wire interEdge = errIntermediate & ~prevInter;
	wire interSafe = interEdge && errImpact != sopc_pkg::IMPACT_NONE;
	wire interReset = interEdge && errImpact[1]; // [RULE18]
	wire bistPass = logic_selftest & analog_selftest_first
		& analog_selftest_second;
	// expected key: bit i of key equals NOT seed bit (15-i)
	wire [sopc_pkg::KEY_W-1:0] expKey;
	for (genvar i = 0; i < sopc_pkg::KEY_W; i++) begin : g_key
		assign expKey[i] = ~watchdog_seed_value[sopc_pkg::KEY_W-1-i]; // [RULE17]
	end
	wire keyOk = keyWrite && safe_output_release_key == expKey;
	wire releaseOk = keyOk && bistPass && errCount == '0 && !bistLock; // [RULE15] [RULE16]
	wire rstLow = pgLow || state != sopc_pkg::SOPC_RUN; // [RULE1]
	wire safeLow = rstLow || safeLatched || forceAll; // [RULE2] [RULE9]
	wire startPulse = resetFault | resetPulseReq | interReset;
	wire [PW-1:0] pulseLen = reset_pulse_length_sel ?
		PW'(TLG_COUNT) : PW'(TST_COUNT); // [RULE12]
	wire feedbackReady = (fbCnt == FBW'(sopc_pkg::TFB_CYC));

	always_comb begin
		next_state = state;
		unique case (state)
			sopc_pkg::SOPC_OFF: begin
				if (!pgLow) next_state = sopc_pkg::SOPC_RESET;
			end
			sopc_pkg::SOPC_RESET: begin
				// power-up release waits for pg, selftest and the timer
				if (pgLow) next_state = sopc_pkg::SOPC_OFF;
				else if (selftestFirstDone && pulseCnt == PW'(TREL_COUNT))
					next_state = sopc_pkg::SOPC_RUN; // [RULE4] [RULE13]
			end
			sopc_pkg::SOPC_PULSE: begin
				if (pgLow) next_state = sopc_pkg::SOPC_OFF;
				else if (pulseCnt == pulseLen) next_state = sopc_pkg::SOPC_RUN;
			end
			sopc_pkg::SOPC_RUN: begin
				if (pgLow) next_state = sopc_pkg::SOPC_OFF;
				else if (startPulse) next_state = sopc_pkg::SOPC_PULSE;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state <= sopc_pkg::SOPC_OFF;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n || next_state != state) begin
			pulseCnt <= '0;
		end else if (pulseCnt != '1) begin
			pulseCnt <= pulseCnt + PW'(1);
		end
	end

	// stuck-low timer counts only while reset is driven low
	always_ff @(posedge clock) begin
		if (!rst_n || !rstLow) begin
			lowCnt <= '0;
		end else if (lowCnt != TW'(T8S_COUNT)) begin
			lowCnt <= lowCnt + TW'(1);
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			deep_failsafe_mode <= 1'b0;
		end else if (lowCnt == TW'(T8S_COUNT)) begin
			deep_failsafe_mode <= 1'b1; // [RULE11]
		end
	end

	// set beats release; a wrong key does nothing
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			safeLatched <= 1'b1;
		end else if (safeFault || safeReq || interSafe || resetShortHigh
			|| !bistPass) begin
			safeLatched <= 1'b1; // [RULE10]
		end else if (releaseOk) begin
			safeLatched <= 1'b0; // [RULE21]
		end
	end

	// a failed selftest latches and blocks release until reset
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			bistLock <= 1'b0;
		end else if (selftestFirstDone && !initPhase && !bistPass) begin
			bistLock <= 1'b1; // [RULE19]
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			prevInter <= 1'b0;
			keyMismatch <= 1'b0;
		end else begin
			prevInter <= errIntermediate;
			keyMismatch <= keyWrite & ~keyOk;
		end
	end

	// readback waits out the feedback filter after any reset or safe-state drive change
	always_ff @(posedge clock) begin
		if (!rst_n || rstLow != ~reset_out_n || safeLow != ~safe_state_out_n) begin
			fbCnt <= '0;
		end else if (!feedbackReady) begin
			fbCnt <= fbCnt + FBW'(1); // [RULE20]
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			power_good_out <= 1'b0;
			reset_out_n <= 1'b0;
			safe_state_out_n <= 1'b0;
		end else begin
			power_good_out <= ~pgLow;
			reset_out_n <= ~rstLow;
			safe_state_out_n <= ~safeLow; // [RULE3]
		end
	end

	// oe low means the pin is pulled down
	assign powerGoodOe = power_good_out;
	assign resetOe = reset_out_n;
	assign safeOe = safe_state_out_n;

	sopc_pin_filter #(.COUNT(TSC_COUNT)) uResetShort (
		.clock(clock),
		.rst_n(rst_n),
		.drivenLow(~reset_out_n & feedbackReady),
		.pinIn(resetIn),
		.shorted(resetShortHigh) // [RULE14]
	);

	sopc_pin_filter #(.COUNT(TSC_COUNT)) uSafeShort (
		.clock(clock),
		.rst_n(rst_n),
		.drivenLow(~safe_state_out_n & feedbackReady),
		.pinIn(safeIn),
		.shorted(safeShortHigh) // [RULE14]
	);

	wire unusedPg = powerGoodIn;

	property p_pg_hier;
		@(posedge clock) disable iff (!rst_n)
		!power_good_out |-> !reset_out_n && !safe_state_out_n;
	endproperty
	a_pg_hier: assert property (p_pg_hier) else $error("pg low, others high"); // [RULE1]

	property p_rst_hier;
		@(posedge clock) disable iff (!rst_n)
		!reset_out_n |-> !safe_state_out_n;
	endproperty
	a_rst_hier: assert property (p_rst_hier) else $error("reset low, safe high"); // [RULE2]

	property p_rail;
		@(posedge clock) disable iff (!rst_n)
		railFault |=> !power_good_out;
	endproperty
	a_rail: assert property (p_rail) else $error("rail fault, pg high"); // [RULE5]

	property p_lowpower;
		@(posedge clock) disable iff (!rst_n)
		forceAll |=> !power_good_out && !reset_out_n && !safe_state_out_n;
	endproperty
	a_lowpower: assert property (p_lowpower) else $error("outputs not low"); // [RULE7]

	property p_safe_only;
		@(posedge clock) disable iff (!rst_n)
		reset_out_n && !pgLow && !startPulse && state == sopc_pkg::SOPC_RUN
		|=> reset_out_n;
	endproperty
	a_safe_only: assert property (p_safe_only) else $error("reset dropped"); // [RULE3]

	sequence s_release;
		!safe_state_out_n ##1 safe_state_out_n;
	endsequence
	property p_release_gate;
		@(posedge clock) disable iff (!rst_n)
		s_release |-> $past(bistPass, 2) && !$past(bistLock, 2);
	endproperty
	a_release_gate: assert property (p_release_gate) else $error("bad release"); // [RULE15]

	property p_badkey;
		@(posedge clock) disable iff (!rst_n)
		keyWrite && !keyOk && safeLatched |=> safeLatched;
	endproperty
	a_badkey: assert property (p_badkey) else $error("wrong key released"); // [RULE21]

	property p_deep;
		@(posedge clock) disable iff (!rst_n)
		lowCnt == TW'(T8S_COUNT) |=> deep_failsafe_mode;
	endproperty
	a_deep: assert property (p_deep) else $error("no deep failsafe"); // [RULE11]

	property p_pulse;
		@(posedge clock) disable iff (!rst_n)
		state == sopc_pkg::SOPC_RUN && startPulse && !pgLow
		|=> state == sopc_pkg::SOPC_PULSE;
	endproperty
	a_pulse: assert property (p_pulse) else $error("no reset pulse"); // [RULE12]
endmodule // sopc_safety_outputs

/* File: include/sopc_pkg.sv */
/*
 Shared constants for the safety output pin control block: timing
 counts at the 50 MHz safety logic clock, field layouts and modes.
 Assumes a single clock and no register bus of its own.
*/
package sopc_pkg;
	localparam int CLK_MHZ = 50;
	// timings in their printed units
	localparam int T8S_NOM_MS = 8000;
	localparam int TLG_MIN_US = 9000;
	localparam int TLG_MAX_US = 11000;
	localparam int TST_MIN_US = 900;
	localparam int TST_MAX_US = 1100;
	localparam int TRELEASE_MS = 8;
	localparam int TSC_MIN_US = 500;
	localparam int TSC_MAX_US = 800;
	localparam int TFB_MIN_NS = 8000;
	localparam int TFB_MAX_NS = 15000;
	// cycle counts derived from the timings
	localparam int T8S_CYC = T8S_NOM_MS * 1000 * CLK_MHZ;
	localparam int TLG_CYC = (TLG_MIN_US + TLG_MAX_US) / 2 * CLK_MHZ;
	localparam int TST_CYC = (TST_MIN_US + TST_MAX_US) / 2 * CLK_MHZ;
	localparam int TREL_CYC = TRELEASE_MS * 1000 * CLK_MHZ;
	localparam int TSC_CYC = (TSC_MIN_US + TSC_MAX_US) / 2 * CLK_MHZ;
	localparam int TFB_CYC = (TFB_MIN_NS * CLK_MHZ + 999) / 1000;
	// rail select bit positions
	localparam int RAIL_CORE = 0;
	localparam int RAIL_IO = 1;
	localparam int RAIL_EXT = 2;
	localparam int NRAIL = 3;
	// key field
	localparam int KEY_W = 16;
	// error-counter impact encodings
	localparam logic [1:0] IMPACT_NONE = 2'h0;
	localparam logic [1:0] IMPACT_SAFE = 2'h1;
	typedef enum logic [1:0] {
		SOPC_OFF,
		SOPC_RESET,
		SOPC_PULSE,
		SOPC_RUN
	} sopc_state_t;
endpackage

/* File: tb/sopc_mcu_model.sv */
/*
 pin side model: pull-ups on the three open-drain pins, optional short
 to high on reset and safe-state. assumes oe low pulls a pin low.
*/
`timescale 1ns/1ns
module sopc_mcu_model (
	input wire logic powerGoodOe,
	input wire logic resetOe,
	input wire logic safeOe,
	input wire logic shortHigh,
	output logic powerGoodIn,
	output logic resetIn,
	output logic safeIn
);
	// released pins float to the pull-up level
	assign powerGoodIn = powerGoodOe;
	// a short to the supply wins over the device's pull-down
	assign resetIn = resetOe | shortHigh;
	assign safeIn = safeOe | shortHigh;
endmodule // sopc_mcu_model

/* File: tb/tb_safety_output_pin_control.sv */
/*
 scenario testbench for the safety output block with a pin model.
 assumes shortened counts and a 50 MHz clock.
*/
`timescale 1ns/1ns
module tb_safety_output_pin_control;
	localparam int TST = 10;
	localparam int TLG = 50;
	localparam int T8S = 200;
	logic clock, rst_n, lowPowerMode, logicFail, initPhase, shortHigh;
	logic [2:0] railUnder, railOver, otpRailSel;
	logic [3:0] faultEvent, cfgResetImpact, cfgSafeImpact, errCount;
	logic reset_pulse_length_sel, resetPulseReq, safeReq, errIntermediate;
	logic [1:0] errImpact;
	logic selftestFirstDone, logic_selftest, keyWrite, anyUp;
	logic analog_selftest_first, analog_selftest_second;
	logic [15:0] watchdog_seed_value, safe_output_release_key;
	logic powerGoodIn, resetIn, safeIn, powerGoodOe, resetOe, safeOe;
	logic power_good_out, reset_out_n, safe_state_out_n;
	logic resetShortHigh, safeShortHigh, deep_failsafe_mode, keyMismatch;
	int errors, samples_checked;
	assign anyUp = power_good_out | reset_out_n | safe_state_out_n;
	sopc_safety_outputs #(.T8S_COUNT(T8S), .TLG_COUNT(TLG),
		.TST_COUNT(TST), .TREL_COUNT(20), .TSC_COUNT(8)) DUT (
		.clock, .rst_n, .lowPowerMode, .logicFail, .railUnder, .railOver,
		.otpRailSel, .faultEvent, .cfgResetImpact, .cfgSafeImpact,
		.initPhase, .reset_pulse_length_sel, .resetPulseReq, .safeReq,
		.errCount, .errIntermediate, .errImpact, .selftestFirstDone,
		.logic_selftest, .analog_selftest_first, .analog_selftest_second,
		.watchdog_seed_value, .keyWrite, .safe_output_release_key,
		.powerGoodIn, .resetIn, .safeIn, .powerGoodOe, .resetOe, .safeOe,
		.power_good_out, .reset_out_n, .safe_state_out_n, .resetShortHigh,
		.safeShortHigh, .deep_failsafe_mode, .keyMismatch);
	sopc_mcu_model MCU (.powerGoodOe, .resetOe, .safeOe, .shortHigh,
		.powerGoodIn, .resetIn, .safeIn);
	task automatic step(input int c);
		repeat (c) @(posedge clock);
		#2;
	endtask
	task automatic chk(input logic got, input logic exp, input string m);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask
	function automatic logic sig(input int k);
		case (k)
			0: return reset_out_n;
			1: return deep_failsafe_mode;
			2: return safeShortHigh;
			default: return resetShortHigh;
		endcase
	endfunction
	// bounded wait for a flag to rise, n counts the cycles spent
	task automatic wt(input int k, input int lim, output int n);
		n = 0;
		while (sig(k) !== 1'h1 && n < lim) begin
			step(1);
			n++;
		end
	endtask
	function automatic logic [15:0] goodKey(input logic [15:0] s);
		for (int i = 0; i < 16; i++)
			goodKey[i] = ~s[15 - i];
	endfunction
	task automatic wkey(input logic [15:0] k);
		safe_output_release_key = k;
		keyWrite = 1'h1;
		step(1);
		chk(keyMismatch, k !== goodKey(watchdog_seed_value), "flag");
		keyWrite = 1'h0;
		step(3);
	endtask
	task automatic boot(input logic lt);
		int n;
		rst_n = 1'h0;
		logic_selftest = lt;
		initPhase = 1'h1;
		step(5);
		rst_n = 1'h1;
		wt(0, 200, n);
		initPhase = 1'h0;
		chk(n >= 20, 1'h1, "early release");
		chk(reset_out_n, 1'h1, "reset held");
		chk(power_good_out, 1'h1, "pg held");
	endtask
	task automatic t_key();
		wkey(16'h0000);
		chk(safe_state_out_n, 1'h0, "bad key took");
		chk(reset_out_n, 1'h1, "bad key hit reset");
		wkey(~watchdog_seed_value);
		chk(safe_state_out_n, 1'h0, "unreversed key took");
		errCount = 4'h1;
		wkey(goodKey(watchdog_seed_value));
		chk(safe_state_out_n, 1'h0, "released with errors");
		errCount = 4'h0;
		wkey(goodKey(watchdog_seed_value));
		chk(safe_state_out_n, 1'h1, "good key refused");
		$display("done key");
	endtask
	task automatic t_inter();
		int n;
		for (int m = 1; m < 3; m++) begin
			errImpact = m[1:0];
			errIntermediate = 1'h1;
			step(2);
			chk(safe_state_out_n, 1'h0, "no safe");
			chk(reset_out_n, m == 1, "reset impact");
			errIntermediate = 1'h0;
			wt(0, 200, n);
			wkey(goodKey(watchdog_seed_value));
		end
		$display("done inter");
	endtask
	task automatic t_low();
		for (int i = 0; i < 2; i++) begin
			lowPowerMode = (i == 0);
			logicFail = (i == 1);
			step(2);
			chk(anyUp, 1'h0, "pins not low");
			chk(powerGoodOe | resetOe | safeOe, 1'h0, "oe up");
			lowPowerMode = 1'h0;
			logicFail = 1'h0;
			boot(1'h1);
			wkey(goodKey(watchdog_seed_value));
		end
		$display("done low");
	endtask
	task automatic t_fault();
		int n;
		faultEvent = 4'h1;
		step(1);
		faultEvent = 4'h0;
		step(2);
		chk(safe_state_out_n, 1'h0, "safe fault lost");
		chk(reset_out_n & power_good_out, 1'h1, "forced up");
		faultEvent = 4'h2;
		step(1);
		faultEvent = 4'h0;
		step(2);
		chk(reset_out_n, 1'h0, "reset fault lost");
		// let the fault pulse finish so the next pulse starts from run
		wt(0, 200, n);
		$display("done fault");
	endtask
	task automatic t_pulse();
		int n;
		for (int s = 0; s < 2; s++) begin
			reset_pulse_length_sel = s[0];
			resetPulseReq = 1'h1;
			step(1);
			resetPulseReq = 1'h0;
			step(1);
			chk(reset_out_n, 1'h0, "no pulse");
			chk(safe_state_out_n, 1'h0, "safe up");
			wt(0, 200, n);
			chk(n == (s ? TLG : TST) + 1, 1'h1, "pulse length");
		end
		$display("done pulse");
	endtask
	task automatic t_rail();
		railUnder = 3'h7;
		otpRailSel = 3'h0;
		step(3);
		chk(power_good_out, 1'h1, "unassigned rail");
		railUnder = 3'h0;
		for (int i = 0; i < 6; i++) begin
			otpRailSel = 3'h1 << (i % 3);
			if (i < 3)
				railUnder = otpRailSel;
			else
				railOver = otpRailSel;
			step(2);
			chk(power_good_out, 1'h0, "rail fault lost");
			chk(anyUp, 1'h0, "pg alone");
			{railUnder, railOver} = 6'h00;
			boot(1'h1);
		end
		$display("done rail");
	endtask
	task automatic t_short();
		int n;
		shortHigh = 1'h1;
		wt(2, 800, n);
		chk(safeShortHigh, 1'h1, "short lost");
		chk(n >= 8, 1'h1, "short fast");
		shortHigh = 1'h0;
		$display("done short");
	endtask
	task automatic t_bist();
		boot(1'h0);
		wkey(goodKey(watchdog_seed_value));
		chk(safe_state_out_n, 1'h0, "bist fail up");
		logic_selftest = 1'h1;
		wkey(goodKey(watchdog_seed_value));
		chk(safe_state_out_n, 1'h0, "lock lost");
		$display("done bist");
	endtask
	task automatic t_deep();
		int n;
		boot(1'h1);
		// fault a rail that is really assigned to power good
		railUnder = otpRailSel;
		wt(1, 400, n);
		chk(deep_failsafe_mode, 1'h1, "no deep");
		chk(n > T8S, 1'h1, "deep early");
		shortHigh = 1'h1;
		wt(3, 800, n);
		chk(resetShortHigh, 1'h1, "reset short lost");
		chk(n >= 8, 1'h1, "reset short fast");
		shortHigh = 1'h0;
		$display("done deep");
	endtask
	task automatic end_of_test();
		$display("errors %0d checks %0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		clock = 1'h0;
		forever #10 clock = ~clock;
	end
	initial begin
		#200000;
		errors++;
		end_of_test();
	end
	initial begin
		{lowPowerMode, logicFail, shortHigh, resetPulseReq, safeReq} = '0;
		{keyWrite, errIntermediate, reset_pulse_length_sel} = '0;
		{railUnder, railOver, faultEvent, errCount, errImpact} = '0;
		otpRailSel = 3'h1;
		cfgSafeImpact = 4'h1;
		cfgResetImpact = 4'h2;
		selftestFirstDone = 1'h1;
		analog_selftest_first = 1'h1;
		analog_selftest_second = 1'h1;
		watchdog_seed_value = 16'h1234;
		safe_output_release_key = 16'h0000;
		boot(1'h1);
		t_key();
		t_inter();
		wkey(goodKey(watchdog_seed_value));
		t_low();
		t_fault();
		t_pulse();
		t_rail();
		t_short();
		t_bist();
		t_deep();
		end_of_test();
	end
endmodule // tb_safety_output_pin_control
